// ==== rtl/csbh_consts.vh ====
/*
 * Constants for the command/status block handler: status block word offsets,
 * flags byte bit positions, selector codes, sense/CDB-length thresholds and an error code.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef CSBH_CONSTS_VH
`define CSBH_CONSTS_VH

`define CSBH_SB_OFS_ID 8'h00
`define CSBH_SB_OFS_FLAGS 8'h04
`define CSBH_SB_OFS_INFO0 8'h08
`define CSBH_SB_OFS_INFO1 8'h0C

`define CSBH_FLG_DONE 7
`define CSBH_FLG_FAIL 6
`define CSBH_FLG_RETRIED 5
`define CSBH_FLG_SHORT 4
`define CSBH_FLG_OVERRUN 3
`define CSBH_FLG_CONT 2
`define CSBH_FLG_ZERO 1
`define CSBH_FLG_RESP 0

`define CSBH_SEL_BOARD 8'hFF
`define CSBH_SEL_MAX_BUS 8'h0F
`define CSBH_SENSE_PER_BLK 8'h08
`define CSBH_CDB_SHORT_LEN 8'h06
`define CSBH_ERR_BAD_SEL 8'h01

`endif

// ==== rtl/csbh_status_writer.v ====
/*
 * Status block writer: emits one 16-byte status block as four word writes,
 * identifier first, then info words, flags/error word last.
 * Assumes the memory side accepts a write when wr_ready is high.
 */
`timescale 1ns/10ps
`default_nettype none

module csbh_status_writer (
    input wire clk,
    input wire reset,
    input wire start,
    input wire [31:0] cmd_id,
    input wire [7:0] flags,
    input wire [7:0] err_code,
    input wire [31:0] info0,
    input wire [31:0] info1,
    output wire busy,
    output reg done_pulse,
    output reg wr_valid,
    output reg [7:0] wr_addr,
    output reg [31:0] wr_data,
    input wire wr_ready
);

`include "csbh_consts.vh"

    reg [2:0] step_r;
    reg [31:0] id_r;
    reg [31:0] fw_r;
    reg [31:0] i0_r;
    reg [31:0] i1_r;

    assign busy = (step_r != 3'h0) || start;

    always @(posedge clk) begin
        if (reset) begin
            step_r <= 3'h0;
            done_pulse <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            id_r <= 32'h00000000;
            fw_r <= 32'h00000000;
            i0_r <= 32'h00000000;
            i1_r <= 32'h00000000;
        end else begin
            done_pulse <= 1'b0;
            if (step_r == 3'h0) begin
                if (start) begin
                    id_r <= cmd_id;
                    fw_r <= {16'h0000, err_code, flags};
                    i0_r <= info0;
                    i1_r <= info1;
                    wr_valid <= 1'b1;
                    wr_addr <= `CSBH_SB_OFS_ID;
                    wr_data <= cmd_id;
                    step_r <= 3'h1;
                end
            end else if (wr_ready) begin
                case (step_r)
                    3'h1: begin
                        wr_addr <= `CSBH_SB_OFS_INFO0;
                        wr_data <= i0_r;
                        step_r <= 3'h2;
                    end
                    3'h2: begin
                        wr_addr <= `CSBH_SB_OFS_INFO1;
                        wr_data <= i1_r;
                        step_r <= 3'h3;
                    end
                    3'h3: begin
                        // flags go last so a poller never sees done over stale words
                        wr_addr <= `CSBH_SB_OFS_FLAGS;
                        wr_data <= fw_r;
                        step_r <= 3'h4;
                    end
                    default: begin
                        wr_valid <= 1'b0;
                        done_pulse <= 1'b1;
                        step_r <= 3'h0;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== rtl/csbh_handler.v ====
/*
 * Command intake and status reporting: decodes the target selector, routes to
 * bus or board-control handling, and builds every status block of a command.
 * Assumes command fields are stable while cmd_valid is high and that the bus
 * side and board side each answer with a one-cycle result pulse.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - status word zero echoes command identifier
// - selector FFH runs board-control internally
// - selector 0..15 forwards command to bus
// - flags byte bit layout fixed
// - responder flag only for target responses
// - continuation flag set on later sense blocks
// - overrun flag when device asked more bytes
// - short flag when fewer bytes moved
// - retried flag when any retry happened
// - failure flag on erroneous completion
// - completion flag only on final block
// - adapter error code in error byte
// - single command returns exactly one block, except a long-CDB target-mode response
// - retry and sense multi blocks need options, pass-through, list
// - target-mode response with long CDB gives two blocks
// - per-retry status blocks when enabled
// - over eight sense bytes gives several blocks
// - retry and sense series repeat per retry
// - info words carry SCSI status and sense
module csbh_handler (
    input wire clk,
    input wire reset,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [31:0] cmd_id,
    input wire [7:0] target_selector,
    input wire [7:0] cmd_code,
    input wire cmd_from_list,
    input wire target_mode,
    input wire target_response,
    input wire [7:0] cdb_length,
    input wire [7:0] retry_limit,
    input wire retry_type_sel,
    input wire per_retry_status_enable,
    input wire [7:0] sense_count,
    output reg bus_req,
    output reg [3:0] bus_target,
    output reg [7:0] bus_cmd_code,
    input wire bus_done,
    input wire bus_error,
    input wire bus_overrun,
    input wire bus_short,
    input wire [7:0] bus_scsi_status,
    input wire [7:0] bus_err_code,
    output reg board_req,
    output reg [7:0] board_cmd_code,
    input wire board_done,
    input wire board_error,
    input wire [7:0] board_err_code,
    output reg sense_rd,
    output reg [7:0] sense_idx,
    input wire [7:0] sense_byte,
    output wire wr_valid,
    output wire [7:0] wr_addr,
    output wire [31:0] wr_data,
    input wire wr_ready,
    output reg cmd_finished
);

`include "csbh_consts.vh"

    localparam ST_IDLE = 3'd0;
    localparam ST_BUS = 3'd1;
    localparam ST_BOARD = 3'd2;
    localparam ST_SENSE = 3'd3;
    localparam ST_EMIT = 3'd4;
    localparam ST_WAIT = 3'd5;

    function [7:0] pack_flags;
        input done;
        input fail;
        input retried;
        input shrt;
        input ovr;
        input cont;
        input resp;
        begin
            pack_flags = 8'h00;
            pack_flags[`CSBH_FLG_DONE] = done;
            pack_flags[`CSBH_FLG_FAIL] = fail;
            pack_flags[`CSBH_FLG_RETRIED] = retried;
            pack_flags[`CSBH_FLG_SHORT] = shrt;
            pack_flags[`CSBH_FLG_OVERRUN] = ovr;
            pack_flags[`CSBH_FLG_CONT] = cont;
            pack_flags[`CSBH_FLG_ZERO] = 1'b0;
            pack_flags[`CSBH_FLG_RESP] = resp;
        end
    endfunction

    reg [2:0] state_r;
    reg [31:0] id_r;
    reg [7:0] code_r;
    reg is_board_r;
    reg from_list_r;
    reg tmode_r;
    reg tresp_r;
    reg [7:0] cdb_len_r;
    reg [7:0] retries_left_r;
    reg retried_r;
    reg per_retry_r;
    reg [7:0] sense_cnt_r;
    reg fail_r;
    reg ovr_r;
    reg short_r;
    reg [7:0] err_r;
    reg [7:0] scsi_stat_r;
    reg [63:0] sense_buf_r;
    reg [7:0] sense_pos_r;
    reg [3:0] fill_r;
    reg cont_r;
    reg final_r;
    reg [1:0] tm_blk_r;
    reg sw_start_r;
    reg [7:0] sw_flags_r;
    reg [31:0] sw_info0_r;
    reg [31:0] sw_info1_r;

    wire sw_busy;
    wire sw_done;
    wire sel_board = (target_selector == `CSBH_SEL_BOARD);
    wire sel_bus = (target_selector <= `CSBH_SEL_MAX_BUS);
    // extended series only for list-issued pass-through commands
    wire multi_ok = from_list_r && !is_board_r && !tmode_r;
    wire sense_multi = multi_ok && (sense_cnt_r > `CSBH_SENSE_PER_BLK);
    wire retry_ok = (retries_left_r != 8'h00) && !is_board_r;

    assign cmd_ready = (state_r == ST_IDLE);

    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            id_r <= 32'h00000000;
            code_r <= 8'h00;
            is_board_r <= 1'b0;
            from_list_r <= 1'b0;
            tmode_r <= 1'b0;
            tresp_r <= 1'b0;
            cdb_len_r <= 8'h00;
            retries_left_r <= 8'h00;
            retried_r <= 1'b0;
            per_retry_r <= 1'b0;
            sense_cnt_r <= 8'h00;
            fail_r <= 1'b0;
            ovr_r <= 1'b0;
            short_r <= 1'b0;
            err_r <= 8'h00;
            scsi_stat_r <= 8'h00;
            sense_buf_r <= 64'h0000000000000000;
            sense_pos_r <= 8'h00;
            fill_r <= 4'h0;
            cont_r <= 1'b0;
            final_r <= 1'b0;
            tm_blk_r <= 2'h0;
            sw_start_r <= 1'b0;
            sw_flags_r <= 8'h00;
            sw_info0_r <= 32'h00000000;
            sw_info1_r <= 32'h00000000;
            bus_req <= 1'b0;
            bus_target <= 4'h0;
            bus_cmd_code <= 8'h00;
            board_req <= 1'b0;
            board_cmd_code <= 8'h00;
            sense_rd <= 1'b0;
            sense_idx <= 8'h00;
            cmd_finished <= 1'b0;
        end else begin
            sw_start_r <= 1'b0;
            bus_req <= 1'b0;
            board_req <= 1'b0;
            sense_rd <= 1'b0;
            cmd_finished <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        id_r <= cmd_id;
                        code_r <= cmd_code;
                        is_board_r <= sel_board;
                        from_list_r <= cmd_from_list;
                        tmode_r <= target_mode;
                        tresp_r <= target_response;
                        cdb_len_r <= cdb_length;
                        retried_r <= 1'b0;
                        cont_r <= 1'b0;
                        tm_blk_r <= 2'h0;
                        fail_r <= 1'b0;
                        ovr_r <= 1'b0;
                        short_r <= 1'b0;
                        err_r <= 8'h00;
                        scsi_stat_r <= 8'h00;
                        sense_buf_r <= 64'h0000000000000000;
                        // retries need a limit and a retry type
                        retries_left_r <= retry_type_sel ? retry_limit : 8'h00;
                        per_retry_r <= per_retry_status_enable && retry_type_sel && (retry_limit != 8'h00);
                        sense_cnt_r <= sense_count;
                        sense_pos_r <= sense_count;
                        if (sel_board) begin
                            board_req <= 1'b1;
                            board_cmd_code <= cmd_code;
                            state_r <= ST_BOARD;
                        end else if (sel_bus) begin
                            bus_req <= 1'b1;
                            bus_target <= target_selector[3:0];
                            bus_cmd_code <= cmd_code;
                            state_r <= ST_BUS;
                        end else begin
                            // unknown selector: report failure without touching the bus
                            fail_r <= 1'b1;
                            err_r <= `CSBH_ERR_BAD_SEL;
                            final_r <= 1'b1;
                            state_r <= ST_EMIT;
                        end
                    end
                end
                ST_BOARD: begin
                    if (board_done) begin
                        fail_r <= board_error;
                        err_r <= board_err_code;
                        final_r <= 1'b1;
                        state_r <= ST_EMIT;
                    end
                end
                ST_BUS: begin
                    if (bus_done) begin
                        fail_r <= bus_error;
                        err_r <= bus_err_code;
                        ovr_r <= bus_overrun;
                        short_r <= bus_short;
                        scsi_stat_r <= bus_scsi_status;
                        fill_r <= 4'h0;
                        cont_r <= 1'b0;
                        final_r <= !(bus_error && retry_ok);
                        if (bus_error && sense_cnt_r != 8'h00 && !tmode_r) begin
                            sense_rd <= 1'b1;
                            sense_idx <= 8'h00;
                            sense_pos_r <= 8'h00;
                            state_r <= ST_SENSE;
                        end else begin
                            state_r <= ST_EMIT;
                        end
                    end
                end
                ST_SENSE: begin
                    // one sense byte per cycle, eight per block
                    sense_buf_r <= {sense_buf_r[55:0], sense_byte};
                    sense_pos_r <= sense_pos_r + 8'h01;
                    fill_r <= fill_r + 4'h1;
                    if (fill_r == 4'h7 || sense_pos_r + 8'h01 == sense_cnt_r) begin
                        state_r <= ST_EMIT;
                    end else begin
                        sense_rd <= 1'b1;
                        sense_idx <= sense_pos_r + 8'h01;
                    end
                end
                ST_EMIT: begin
                    if (!sw_busy) begin
                        sw_start_r <= 1'b1;
                        sw_info0_r <= {scsi_stat_r, sense_buf_r[63:40]};
                        sw_info1_r <= sense_buf_r[39:8];
                        state_r <= ST_WAIT;
                        // done only on the last block of the whole command
                        if (tmode_r && tresp_r && cdb_len_r > `CSBH_CDB_SHORT_LEN && tm_blk_r == 2'h0) begin
                            sw_flags_r <= pack_flags(1'b0, fail_r, 1'b0, 1'b0, 1'b0, 1'b0, tresp_r);
                        end else if (sense_multi && sense_pos_r < sense_cnt_r) begin
                            sw_flags_r <= pack_flags(1'b0, fail_r, retried_r, short_r, ovr_r, cont_r, 1'b0);
                        end else if (!final_r && !(multi_ok && (per_retry_r || cont_r))) begin
                            sw_start_r <= 1'b0; // single command or no per-retry status: suppress
                            state_r <= ST_WAIT;
                        end else begin
                            sw_flags_r <= pack_flags(final_r, fail_r, retried_r, short_r, ovr_r,
                                                     cont_r && multi_ok, tresp_r && tmode_r);
                        end
                    end
                end
                ST_WAIT: begin
                    if (sw_done || !sw_start_r && !sw_busy) begin
                        if (tmode_r && tresp_r && cdb_len_r > `CSBH_CDB_SHORT_LEN && tm_blk_r == 2'h0) begin
                            tm_blk_r <= 2'h1;
                            state_r <= ST_EMIT;
                        end else if (sense_multi && sense_pos_r < sense_cnt_r) begin
                            cont_r <= 1'b1;
                            fill_r <= 4'h0;
                            sense_rd <= 1'b1;
                            sense_idx <= sense_pos_r;
                            state_r <= ST_SENSE;
                        end else if (!final_r) begin
                            // retry: new series, repeats until success or limit
                            retries_left_r <= retries_left_r - 8'h01;
                            retried_r <= 1'b1;
                            cont_r <= 1'b0;
                            bus_req <= 1'b1;
                            state_r <= ST_BUS;
                        end else begin
                            cmd_finished <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    csbh_status_writer u_writer (
        .clk(clk),
        .reset(reset),
        .start(sw_start_r),
        .cmd_id(id_r),
        .flags(sw_flags_r),
        .err_code(err_r),
        .info0(sw_info0_r),
        .info1(sw_info1_r),
        .busy(sw_busy),
        .done_pulse(sw_done),
        .wr_valid(wr_valid),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_ready(wr_ready)
    );

endmodule

`default_nettype wire

// ==== verification/csbh_handler_props.sv ====
/*
 * Checker for csbh_handler: intake routing and status word sequencing.
 * Assumes it is bound onto the handler and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module csbh_handler_props (
    input wire clk,
    input wire reset,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire [7:0] target_selector,
    input wire [7:0] cmd_code,
    input wire target_mode,
    input wire bus_req,
    input wire [3:0] bus_target,
    input wire [7:0] bus_cmd_code,
    input wire board_req,
    input wire [7:0] board_cmd_code,
    input wire wr_valid,
    input wire [7:0] wr_addr,
    input wire [31:0] wr_data,
    input wire wr_ready,
    input wire cmd_finished
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire take = cmd_valid && cmd_ready;
    property p_bus_fwd;
        take && !target_mode && target_selector <= 8'h0F |=> bus_req && !board_req
            && bus_target == $past(target_selector[3:0]) && bus_cmd_code == $past(cmd_code);
    endproperty
    a_bus_fwd: assert property (p_bus_fwd) else $error("bus command not forwarded");
    property p_board;
        take && target_selector == 8'hFF |=> board_req && !bus_req && board_cmd_code == $past(cmd_code);
    endproperty
    a_board: assert property (p_board) else $error("board command not run");
    property p_bad_sel;
        take && target_selector > 8'h0F && target_selector != 8'hFF |=> !bus_req && !board_req;
    endproperty
    a_bad_sel: assert property (p_bad_sel) else $error("bad selector issued a request");
    property p_zero_bit;
        wr_valid && wr_addr == 8'h04 |-> !wr_data[1];
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("flags bit 1 set");
    property p_id_first;
        wr_valid && wr_addr == 8'h08 |-> $past(wr_addr) == 8'h00 || $past(wr_addr) == 8'h08;
    endproperty
    a_id_first: assert property (p_id_first) else $error("info word before identifier");
    property p_flags_last;
        wr_valid && wr_addr == 8'h04 |-> $past(wr_addr) == 8'h0C || $past(wr_addr) == 8'h04;
    endproperty
    a_flags_last: assert property (p_flags_last) else $error("flags word not last");
    property p_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_hold: assert property (p_hold) else $error("write dropped before accept");
    property p_finish;
        wr_valid && wr_ready && wr_addr == 8'h04 && wr_data[7] |-> ##[1:3] cmd_finished;
    endproperty
    a_finish: assert property (p_finish) else $error("final block without finish");
endmodule
`default_nettype wire

// ==== verification/csbh_far_model.sv ====
/*
 * Far side of the handler: SCSI bus engine, board-control engine, sense
 * buffer and status memory. Assumes a testbench sets the outcome inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module csbh_far_model (
    input wire clk,
    input wire reset,
    input wire cmd_take,
    input wire bus_req,
    input wire board_req,
    input wire sense_rd,
    input wire [7:0] sense_idx,
    input wire stall,
    input wire [7:0] n_fail,
    input wire ov,
    input wire sh,
    input wire [7:0] st,
    output logic bus_done,
    output logic bus_error,
    output logic bus_overrun,
    output logic bus_short,
    output logic [7:0] bus_scsi_status,
    output logic [7:0] bus_err_code,
    output logic board_done,
    output logic board_error,
    output logic [7:0] board_err_code,
    output logic [7:0] sense_byte,
    output logic wr_ready
);
    logic [7:0] att_r;
    logic [1:0] dly_r;
    logic pend_r;
    assign sense_byte = sense_rd ? (sense_idx ^ 8'h5A) : ~sense_idx;
    always @(posedge clk) begin
        bus_done <= 1'b0;
        board_done <= 1'b0;
        // outcome lines toggle outside their pulse so stale values never match
        {bus_error, bus_overrun, bus_short} <= ~{bus_error, bus_overrun, bus_short};
        bus_scsi_status <= ~bus_scsi_status;
        board_error <= ~board_error;
        if (reset) begin
            pend_r <= 1'b0;
            att_r <= 8'h00;
            wr_ready <= 1'b0;
            bus_err_code <= 8'h04;
            board_err_code <= 8'h04;
        end else begin
            wr_ready <= !stall;
            if (cmd_take)
                att_r <= 8'h00;
            if (bus_req) begin
                pend_r <= 1'b1;
                dly_r <= {stall, 1'b1};
            end else if (pend_r && dly_r != 2'b00) begin
                dly_r <= dly_r - 2'b01;
            end else if (pend_r) begin
                pend_r <= 1'b0;
                bus_done <= 1'b1;
                bus_error <= att_r < n_fail;
                {bus_overrun, bus_short} <= {ov, sh};
                bus_scsi_status <= st;
                att_r <= att_r + 8'h01;
            end
            if (board_req) begin
                board_done <= 1'b1;
                board_error <= n_fail != 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/csbh_handler_tb.sv ====
/*
 * Self-checking bench for csbh_handler: commands go in one at a time, the
 * expected status blocks are queued and a monitor matches written blocks.
 * Assumes csbh_far_model answers the bus, board and memory sides.
 */
`timescale 1ns/10ps
`default_nettype none
`define CSBH_CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module csbh_handler_tb;
    typedef struct packed {logic [31:0] id; logic [7:0] fl, mk, er, st; logic ce, cs;} csbh_exp_t;
    csbh_exp_t q[$];
    csbh_exp_t e;
    logic clk = 0, reset = 1, cmd_valid = 0, lst = 0, tmode = 0, tresp = 0, rtype = 0, pren = 0;
    logic stall = 0, ov_v = 0, sh_v = 0;
    logic [31:0] cur_id = 0, got_id, got_i0;
    logic [7:0] sel = 0, code = 0, cdb = 0, rlim = 0, n_fail = 0, st_v = 0, sc = 0;
    wire cmd_ready, bus_req, board_req, sense_rd, wr_valid, wr_ready, cmd_finished;
    wire bus_done, bus_error, bus_overrun, bus_short, board_done, board_error;
    wire [3:0] bus_target;
    wire [7:0] bus_cmd_code, bus_scsi_status, bus_err_code, board_cmd_code, board_err_code;
    wire [7:0] sense_idx, sense_byte, wr_addr;
    wire [31:0] wr_data;
    integer seed = 82271, error_cnt = 0, n_checks = 0, cyc = 0, t_no = 0;
    always #50 clk = ~clk;
    csbh_handler dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_id(cur_id), .target_selector(sel), .cmd_code(code), .cmd_from_list(lst),
        .target_mode(tmode), .target_response(tresp), .cdb_length(cdb), .retry_limit(rlim),
        .retry_type_sel(rtype), .per_retry_status_enable(pren), .sense_count(sc),
        .bus_req(bus_req), .bus_target(bus_target), .bus_cmd_code(bus_cmd_code),
        .bus_done(bus_done), .bus_error(bus_error), .bus_overrun(bus_overrun), .bus_short(bus_short),
        .bus_scsi_status(bus_scsi_status), .bus_err_code(bus_err_code), .board_req(board_req),
        .board_cmd_code(board_cmd_code), .board_done(board_done), .board_error(board_error),
        .board_err_code(board_err_code), .sense_rd(sense_rd), .sense_idx(sense_idx),
        .sense_byte(sense_byte), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_ready(wr_ready), .cmd_finished(cmd_finished));
    csbh_far_model far (.clk(clk), .reset(reset), .cmd_take(cmd_valid && cmd_ready),
        .bus_req(bus_req), .board_req(board_req), .sense_rd(sense_rd), .sense_idx(sense_idx),
        .stall(stall), .n_fail(n_fail), .ov(ov_v), .sh(sh_v), .st(st_v), .bus_done(bus_done),
        .bus_error(bus_error), .bus_overrun(bus_overrun), .bus_short(bus_short),
        .bus_scsi_status(bus_scsi_status), .bus_err_code(bus_err_code), .board_done(board_done),
        .board_error(board_error), .board_err_code(board_err_code), .sense_byte(sense_byte),
        .wr_ready(wr_ready));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic push(input [7:0] fl, mk, er, input ce, cs);
        q.push_back({cur_id, fl, mk, er, st_v, ce, cs});
    endtask
    // s: selector, l: list, t/r: target mode/response, c: cdb length, rl: retry limit
    task automatic run(input [7:0] s, input l, t, r, input [7:0] c, rl, input p, input [7:0] nf,
                       input o, h);
        integer k;
        integer n;
        cur_id = $random(seed);
        st_v = $random(seed);
        {sel, lst, tmode, tresp, cdb, rlim, pren, n_fail, ov_v, sh_v} = {s, l, t, r, c, rl, p, nf, o, h};
        rtype = rl != 8'h00;
        code = (s == 8'hFF) ? 8'h05 : 8'h28;
        n = (nf < rl) ? nf : rl;
        if (s == 8'hFF)
            push({1'b1, nf != 8'h00, 6'h00}, 8'hFF, 8'h00, 1'b0, 1'b0);
        else if (s > 8'h0F)
            push(8'hC0, 8'hFF, 8'h01, 1'b1, 1'b0);
        else if (t) begin
            if (c > 8'h06)
                push({7'h00, r}, 8'h83, 8'h00, 1'b0, 1'b0);
            push({1'b1, 6'h00, r}, 8'h83, 8'h00, 1'b0, 1'b0);
        end else begin
            for (k = 0; k < n && l && p; k++)
                push(8'h00, 8'h86, 8'h00, 1'b0, 1'b0);
            if (sc > 8'h08 && l && nf > rl)
                push(8'h40, 8'hC6, 8'h00, 1'b0, 1'b0);
            push({1'b1, nf > rl, n != 0, h, o, sc > 8'h08 && l && nf > rl, 2'b00}, 8'hFF, 8'h00, 1'b0, 1'b1);
        end
        for (k = 0; k < 100 && cmd_ready !== 1'b1; k++)
            @(posedge clk) #10;
        cmd_valid = 1'b1;
        @(posedge clk) #10;
        cmd_valid = 1'b0;
        for (k = 0; k < 3000 && cmd_finished !== 1'b1; k++)
            @(posedge clk) #10;
        `CSBH_CHK(cmd_finished, 1'b1)
        `CSBH_CHK(q.size() == 0, 1'b1)
        t_no++;
        $display("test %0d done", t_no);
    endtask
    // match each finished status block against the oldest note
    always @(negedge clk) begin
        if (!reset && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (wr_addr == 8'h00)
                got_id = wr_data;
            if (wr_addr == 8'h08)
                got_i0 = wr_data;
            if (wr_addr == 8'h04 && q.size() == 0) begin
                error_cnt++;
                $display("[ERR] %0t unexpected status block", $time);
            end else if (wr_addr == 8'h04) begin
                e = q.pop_front();
                `CSBH_CHK(got_id, e.id)
                `CSBH_CHK(wr_data[7:0] & e.mk, e.fl)
                if (e.ce)
                    `CSBH_CHK(wr_data[15:8], e.er)
                if (e.cs)
                    `CSBH_CHK(got_i0[31:24], e.st)
            end
        end
    end
    always @(posedge clk) begin
        stall <= #10 $random(seed);
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("[ERR] %0t run timed out", $time);
            stop_test;
        end
    end
    initial begin : main
        integer i;
        repeat (2) @(posedge clk);
        #10 reset = 1'b0;
        run(8'hFF, 0, 0, 0, 8'h06, 8'h00, 0, 8'h00, 0, 0);
        run(8'hFF, 1, 0, 0, 8'h06, 8'h00, 0, 8'h01, 0, 0);
        run(8'h00, 0, 0, 0, 8'h06, 8'h00, 0, 8'h00, 0, 0);
        run(8'h0F, 1, 0, 0, 8'h0A, 8'h00, 0, 8'h00, 1, 0);
        run(8'h07, 1, 0, 0, 8'h06, 8'h00, 0, 8'h00, 0, 1);
        run(8'h10, 0, 0, 0, 8'h06, 8'h00, 0, 8'h00, 0, 0);
        run(8'hFE, 1, 0, 0, 8'h06, 8'h00, 0, 8'h00, 0, 0);
        run(8'h03, 0, 0, 0, 8'h06, 8'h02, 1, 8'h01, 0, 0);
        run(8'h04, 1, 0, 0, 8'h06, 8'h02, 1, 8'h02, 0, 0);
        run(8'h05, 1, 0, 0, 8'h06, 8'h02, 1, 8'h03, 0, 0);
        run(8'h06, 1, 0, 0, 8'h06, 8'h02, 0, 8'h01, 0, 0);
        sc = 8'h09;
        run(8'h01, 1, 0, 0, 8'h06, 8'h00, 0, 8'h01, 0, 1);
        run(8'h02, 1, 1, 1, 8'h0A, 8'h00, 0, 8'h00, 0, 0);
        run(8'h02, 1, 1, 0, 8'h06, 8'h00, 0, 8'h00, 0, 0);
        for (i = 0; i < 8; i++)
            run($random(seed) & 8'h0F, $random(seed), 0, 0, 8'h06, 8'h00, 0, 8'h00,
                $random(seed), $random(seed));
        stop_test;
    end
endmodule
bind csbh_handler csbh_handler_props u_props (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .target_selector(target_selector), .cmd_code(cmd_code),
    .target_mode(target_mode), .bus_req(bus_req), .bus_target(bus_target),
    .bus_cmd_code(bus_cmd_code), .board_req(board_req), .board_cmd_code(board_cmd_code),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready),
    .cmd_finished(cmd_finished));
`default_nettype wire
